// ==== verilog/sfq_table.sv ====
// spi slave: parameter table bytes and volatile config register 2
`timescale 1ns/1ps
module sfq_table
   import sfq_pkg::*;
(
   // clock and reset
   input  wire logic     mclk,
   input  wire logic     sys_rst,
   // spi pins, mode 0
   input  wire logic     spi_sck,
   input  wire logic     spi_cs_n,
   input  wire logic     spi_mosi,
   output logic          spi_miso,
   output logic          spi_miso_oe,
   // configuration state to the core
   output sfq_cfg_t      cfg
);
   logic [1:0]  sck_s_q, cs_s_q, mosi_s_q;
   logic        sck_d_q;
   logic        rise, fall, cs_n;
   sfq_state_t  st_q;
   logic [7:0]  sh_q;
   logic [5:0]  cnt_q;
   logic [7:0]  op_q;
   logic [23:0] addr_q;
   logic [7:0]  cfg2_q;
   logic [7:0]  out_q;
   logic        inrange;
   logic [1:0]  word_idx;
   logic [7:0]  tbyte;
   logic [7:0]  next_byte;

   // two-flop sync of every spi input pin
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         sck_s_q  <= 2'h0;
         cs_s_q   <= 2'h3;
         mosi_s_q <= 2'h0;
         sck_d_q  <= 1'b0;
      end else begin
         sck_s_q  <= {sck_s_q[0], spi_sck};
         cs_s_q   <= {cs_s_q[0], spi_cs_n};
         mosi_s_q <= {mosi_s_q[0], spi_mosi};
         sck_d_q  <= sck_s_q[1];
      end
   end

   assign cs_n = cs_s_q[1];
   assign rise = sck_s_q[1] & ~sck_d_q;
   assign fall = ~sck_s_q[1] & sck_d_q;

   // byte lookup: ascending offset, low byte of each dword first
   assign inrange  = (addr_q >= TABLE_BASE) && (addr_q <= TABLE_LAST);
   assign word_idx = 2'((addr_q - TABLE_BASE) >> 2);
   always_comb begin
      tbyte = 8'h00;
      if (inrange) begin
         tbyte = TABLE[word_idx][8*addr_q[1:0] +: 8];
      end
   end

   // next byte to shift: table byte or register readback
   always_comb begin
      next_byte = tbyte;
      if (op_q == OP_RD_REG) begin
         next_byte = (addr_q[7:0] == CFG2_ADDR) ? cfg2_q : 8'h00;
      end
   end

   // command sequencer
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_q   <= ST_CMD;
         sh_q   <= 8'h00;
         cnt_q  <= 6'h00;
         op_q   <= 8'h00;
         addr_q <= 24'h000000;
      end else if (cs_n) begin
         st_q  <= ST_CMD;
         cnt_q <= 6'h00;
      end else if (rise) begin
         sh_q  <= {sh_q[6:0], mosi_s_q[1]};
         cnt_q <= cnt_q + 6'h01;
         unique case (st_q)
            ST_CMD: if (cnt_q == BIT_LAST) begin
               op_q  <= {sh_q[6:0], mosi_s_q[1]};
               cnt_q <= 6'h00;
               st_q  <= ST_ADDR;
            end
            ST_ADDR: begin
               // register commands carry an 8-bit address, table reads 24 bits
               addr_q <= {addr_q[22:0], mosi_s_q[1]};
               if ((op_q == OP_RD_TABLE && cnt_q == ADDR_LAST) ||
                   (op_q != OP_RD_TABLE && cnt_q == BIT_LAST)) begin
                  cnt_q <= 6'h00;
                  unique case (op_q)
                     OP_WR_REG:   st_q <= ST_DATA;
                     OP_RD_REG:   st_q <= ST_OUT;
                     OP_RD_TABLE: st_q <= ST_DUMMY;
                     default:     st_q <= ST_IDLE;
                  endcase
               end
            end
            ST_DUMMY: if (cnt_q == 6'(TABLE_DUMMY - 1)) begin
               cnt_q <= 6'h00;
               st_q  <= ST_OUT;
            end
            ST_DATA: if (cnt_q == BIT_LAST) begin
               cnt_q <= 6'h00;
               st_q  <= ST_IDLE;
            end
            ST_OUT: if (cnt_q == BIT_LAST) begin
               cnt_q <= 6'h00;
               if (op_q == OP_RD_TABLE) begin
                  addr_q <= addr_q + 24'h000001;
               end
            end
            ST_IDLE: cnt_q <= 6'h00;
         endcase
      end
   end

   // volatile config register 2, written only at its own address
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cfg2_q <= CFG2_RESET;
      end else if (!cs_n && rise && st_q == ST_DATA && cnt_q == BIT_LAST &&
                   addr_q[7:0] == CFG2_ADDR) begin
         cfg2_q <= {sh_q[6:0], mosi_s_q[1]};
      end
   end

   // shift-out on falling edges; load new byte at start of each output byte
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         out_q       <= 8'h00;
         spi_miso    <= 1'b0;
         spi_miso_oe <= 1'b0;
      end else if (cs_n) begin
         spi_miso_oe <= 1'b0;
      end else if (fall && st_q == ST_OUT) begin
         spi_miso_oe <= 1'b1;
         if (cnt_q == 6'h00) begin
            spi_miso <= next_byte[7];
            out_q    <= {next_byte[6:0], 1'b0};
         end else begin
            spi_miso <= out_q[7];
            out_q    <= {out_q[6:0], 1'b0};
         end
      end
   end

   // configuration outputs
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cfg <= '0;
      end else begin
         cfg.qpi_en   <= cfg2_q[QPI_BIT];
         cfg.wait_sel <= cfg2_q[WAIT_LSB +: WAIT_W];
      end
   end
endmodule : sfq_table

// ==== verilog/sfq_pkg.sv ====
// constants, table content and types for the parameter table and config register 2
// What this block does
// - table advertises 20, 18, 16 wait-state settings unsupported, patterns zero
// - 14 wait states supported, selected by pattern 01110b
// - 12 wait states supported, selected by pattern 01100b
// - 10 wait states supported, selected by pattern 01010b
// - 8 wait states supported, selected by pattern 01000b
// - 6, 4, 2 wait states supported, patterns 00110b, 00100b, 00010b
// - opcode 71h writes the register holding wait-state and quad bits
// - opcode 65h reads back that register
// - wait-state field lives in volatile config register 2 at address 03h
// - those bits change only by address-carrying register commands
// - volatile quad mode enable at bit 3, active high
// - table bytes 384h..387h read b0, 2e, 00, 00
// - table bytes 388h..38bh read 88, a4, 89, aa
// - table bytes 38ch..38fh read 71, 65, 03, 93
package sfq_pkg;
   localparam logic [7:0]  OP_WR_REG      = 8'h71;
   localparam logic [7:0]  OP_RD_REG      = 8'h65;
   localparam logic [7:0]  OP_RD_TABLE    = 8'h5a;
   localparam logic [7:0]  CFG2_ADDR      = 8'h03;
   localparam logic [7:0]  CFG2_RESET     = 8'h00;
   localparam int          QPI_BIT        = 3;
   localparam int          WAIT_LSB       = 3;
   localparam int          WAIT_W         = 5;
   localparam logic [23:0] TABLE_BASE     = 24'h000384;
   localparam logic [23:0] TABLE_LAST     = 24'h00038f;
   localparam int          TABLE_WORDS    = 3;
   localparam int          TABLE_DUMMY    = 8;
   localparam logic [5:0]  BIT_LAST       = 6'h07;
   localparam logic [5:0]  ADDR_LAST      = 6'h17;
   // wait-state patterns
   localparam logic [4:0]  WS_NONE = 5'h00;
   localparam logic [4:0]  WS_14   = 5'h0e;
   localparam logic [4:0]  WS_12   = 5'h0c;
   localparam logic [4:0]  WS_10   = 5'h0a;
   localparam logic [4:0]  WS_8    = 5'h08;
   localparam logic [4:0]  WS_6    = 5'h06;
   localparam logic [4:0]  WS_4    = 5'h04;
   localparam logic [4:0]  WS_2    = 5'h02;
   // dword 12: 20/18/16 off, 14 and 12 on
   localparam logic [31:0] DW12 = {1'b0, WS_NONE, 1'b0, WS_NONE, 1'b0, WS_NONE,
                                   1'b1, WS_14, 1'b1, WS_12, 2'b00};
   // dword 13: 10, 8, 6, 4, 2 on
   localparam logic [31:0] DW13 = {1'b1, WS_10, 1'b1, WS_8, 1'b1, WS_6,
                                   1'b1, WS_4, 1'b1, WS_2, 2'b00};
   // dword 14: qpi enable map
   localparam logic [31:0] DW14 = {1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 3'h3,
                                   CFG2_ADDR, OP_RD_REG, OP_WR_REG};
   localparam logic [31:0] TABLE [TABLE_WORDS] = '{DW12, DW13, DW14};

   typedef enum logic [2:0] {
      ST_CMD   = 3'b000,
      ST_ADDR  = 3'b001,
      ST_DATA  = 3'b010,
      ST_DUMMY = 3'b011,
      ST_OUT   = 3'b100,
      ST_IDLE  = 3'b101
   } sfq_state_t;

   typedef struct packed {
      logic       qpi_en;
      logic [4:0] wait_sel;
   } sfq_cfg_t;
endpackage : sfq_pkg

// ==== dv/sfq_table_monitor.sv ====
// port checker for the parameter table block
`timescale 1ns/1ps
module sfq_table_monitor
   import sfq_pkg::*;
(
   // block pins
   input wire logic     mclk,
   input wire logic     sys_rst,
   input wire logic     spi_sck,
   input wire logic     spi_cs_n,
   input wire logic     spi_miso,
   input wire logic     spi_miso_oe,
   input wire sfq_cfg_t cfg
);
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   a_rst_clear: assert property (disable iff (1'b0)
      sys_rst |=> cfg == '0 && !spi_miso_oe) else $error("reset left state");
   a_cfg_idle: assert property (spi_cs_n [*8] |=> $stable(cfg)) else $error("cfg idle");
   a_cfg_when: assert property (!$stable(cfg) |-> !spi_cs_n && $past(spi_sck, 2))
      else $error("cfg moved off clock");
   a_qpi_rise: assert property ($rose(cfg.qpi_en) |-> !spi_cs_n) else $error("qpi rise");
   a_cfg_read: assert property (spi_miso_oe |-> $stable(cfg)) else $error("cfg in read");
   a_oe_idle: assert property (spi_cs_n [*8] |-> !spi_miso_oe) else $error("oe idle");
   a_oe_early: assert property (spi_cs_n [*8] ##1 !spi_cs_n |=> !spi_miso_oe [*8])
      else $error("oe early");
   a_oe_drop: assert property ($fell(spi_miso_oe) |-> spi_cs_n) else $error("oe drop");
   a_miso_hold: assert property (spi_miso_oe && $changed(spi_miso) |-> !spi_sck)
      else $error("miso moved");
   c_qpi: cover property (cfg.qpi_en);
   c_ws14: cover property (cfg.wait_sel == WS_14);
   c_out: cover property (spi_miso_oe && spi_miso);
endmodule : sfq_table_monitor
bind sfq_table sfq_table_monitor u_mon (.mclk(mclk), .sys_rst(sys_rst), .spi_sck(spi_sck),
   .spi_cs_n(spi_cs_n), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .cfg(cfg));

// ==== dv/sfq_host.sv ====
// host controller model: mode 0 master, a byte at a time
`timescale 1ns/1ps
module sfq_host (
   // clock
   input wire logic mclk,
   // link pins
   output logic     spi_sck = 1'b0,
   output logic     spi_cs_n = 1'b1,
   output logic     spi_mosi = 1'b0,
   input wire logic spi_miso
);
   // 8 mclk a phase gives the 160 ns link period
   task sel;
      @(negedge mclk) spi_cs_n = 1'b0;
      repeat (8) @(negedge mclk);
   endtask : sel
   task x(input logic [7:0] b, output logic [7:0] r);
      for (int i = 7; i >= 0; i--) begin
         spi_mosi = b[i];
         repeat (8) @(negedge mclk);
         spi_sck = 1'b1;
         r[i] = spi_miso;
         repeat (8) @(negedge mclk);
         spi_sck = 1'b0;
      end
   endtask : x
   // idle data line flips so a stale bit is never mistaken
   task desel;
      repeat (8) @(negedge mclk);
      spi_cs_n = 1'b1;
      spi_mosi = ~spi_mosi;
      repeat (8) @(negedge mclk);
   endtask : desel
endmodule : sfq_host

// ==== dv/sfq_table_tb_top.sv ====
// self-checking bench for the parameter table block
`timescale 1ns/1ps
module sfq_table_tb_top;
   import sfq_pkg::*;
   localparam logic [7:0] TBL [13] = '{8'hb0, 8'h2e, 8'h00, 8'h00, 8'h88, 8'ha4, 8'h89,
      8'haa, 8'h71, 8'h65, 8'h03, 8'h93, 8'h00};
   localparam logic [4:0] WS [8] = '{5'h0e, 5'h0c, 5'h0a, 5'h08, 5'h06, 5'h04, 5'h02, 5'h01};
   logic       mclk = 1'b0;
   logic       sys_rst = 1'b1;
   logic       sck, cs_n, mosi, miso, oe;
   sfq_cfg_t   cfg;
   logic [7:0] r;
   int         mismatches = 0;
   int         n_checks = 0;
   always #5 mclk = ~mclk;
   sfq_table dut (.mclk(mclk), .sys_rst(sys_rst), .spi_sck(sck), .spi_cs_n(cs_n),
      .spi_mosi(mosi), .spi_miso(miso), .spi_miso_oe(oe), .cfg(cfg));
   sfq_host host (.mclk(mclk), .spi_sck(sck), .spi_cs_n(cs_n), .spi_mosi(mosi),
      .spi_miso(miso));
   task stop_test;
      if (mismatches == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : stop_test
   task chk(string nm, logic [7:0] e, logic [7:0] s);
      n_checks++;
      if (s !== e) begin
         $display("unexpected %s exp %h got %h", nm, e, s);
         mismatches++;
      end
   endtask : chk
   // three-byte frame; r keeps the last byte in
   task f3(logic [7:0] op, logic [7:0] a, logic [7:0] d);
      host.sel();
      host.x(op, r);
      host.x(a, r);
      host.x(d, r);
      host.desel();
   endtask : f3
   // reads one byte past the end, which must be zero
   task t_table;
      host.sel();
      host.x(OP_RD_TABLE, r);
      host.x(8'h00, r);
      host.x(8'h03, r);
      host.x(8'h84, r);
      host.x(8'h00, r);
      for (int i = 0; i < 13; i++) begin
         host.x(8'h00, r);
         chk("table byte", TBL[i], r);
      end
      chk("miso enable", 8'h01, {7'h00, oe});
      host.desel();
      chk("miso enable idle", 8'h00, {7'h00, oe});
   endtask : t_table
   // each wait pattern, the last one the quad enable alone
   task t_wr_rd;
      for (int i = 0; i < 8; i++) begin
         f3(8'h71, 8'h03, {WS[i], 3'h0});
         chk("wait field", {3'h0, WS[i]}, {3'h0, cfg.wait_sel});
         chk("quad enable", {7'h00, WS[i][0]}, {7'h00, cfg.qpi_en});
         f3(8'h65, 8'h03, 8'h00);
         chk("reg readback", {WS[i], 3'h0}, r);
      end
   endtask : t_wr_rd
   task t_refuse;
      f3(8'h71, 8'h04, 8'hff);
      f3(8'h00, 8'h03, 8'hff);
      f3(8'h65, 8'h04, 8'h00);
      chk("other reg", 8'h00, r);
      f3(8'h65, 8'h03, 8'h00);
      chk("reg kept", 8'h08, r);
   endtask : t_refuse
   initial begin
      repeat (40000) @(posedge mclk);
      mismatches++;
      stop_test();
   end
   initial begin
      repeat (16) @(negedge mclk);
      sys_rst = 1'b0;
      repeat (4) @(negedge mclk);
      chk("cfg reset", 8'h00, {2'h0, cfg});
      t_table();
      t_wr_rd();
      t_refuse();
      stop_test();
   end
endmodule : sfq_table_tb_top
